// >>> design/frp_top.sv
// frp_top: program/data array protection registers, reset load from the
// configuration field, sequencer protection query and violation flag.
// assumes a classic wishbone master and a config reader that answers
// one read request per cycle with data and a double-bit fault flag.
//
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "frp_cfg.svh"
module frp_top
  import frp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // configuration field reader
  output logic             cfg_rd_q,
  output logic [17:0]      cfg_addr_q,
  input  wire logic        cfg_valid,
  input  wire logic [7:0]  cfg_data,
  input  wire logic        cfg_dbl_fault,
  // sequencer query
  input  wire logic        seq_query,
  input  wire logic        seq_data_arr,
  input  wire logic [1:0]  seq_op,
  input  wire logic [17:0] seq_addr,
  output logic             seq_prot,
  input  wire logic        seq_launch,
  output logic             load_done_q
);
  frp_load_t   load_q;
  logic [7:0]  pguard_q;
  logic [7:0]  dguard_q;
  logic [7:0]  sec_q;
  logic [7:0]  opt_q;
  logic        viol_q;
  logic [31:0] rdata_d;
  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  wbyte;
  logic        p_prot;
  logic        d_prot;
  logic        p_hit;
  logic        d_hit;
  logic        blk;
  logic [17:0] d_end;
  logic        pg_grow;
  logic [7:0]  pg_new;

  // bus strobes; one-cycle ack, only first cycle of a request
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign rd_stb = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbyte  = wb_dat_i[7:0];

  // reset-sequence loader walks guard bytes then option/security
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      load_q      <= FRP_LD_PG;
      cfg_rd_q    <= 1'b0;
      cfg_addr_q  <= 18'h0_0000;
      load_done_q <= 1'b0;
    end else begin
      unique case (load_q)
        FRP_LD_PG: begin
          cfg_rd_q   <= 1'b1;
          cfg_addr_q <= `FRP_PGUARD_ADDR; // [R8] [R5]
          if (cfg_valid && cfg_rd_q) begin
            load_q     <= FRP_LD_DG;
            cfg_addr_q <= `FRP_DGUARD_ADDR; // [R5]
          end
        end
        FRP_LD_DG: begin
          if (cfg_valid) begin
            load_q     <= FRP_LD_REST;
            cfg_addr_q <= `FRP_OPT_ADDR; // [R5]
          end
        end
        // option byte first, then security byte
        FRP_LD_REST: begin
          if (cfg_valid && cfg_addr_q == `FRP_OPT_ADDR) begin
            cfg_addr_q <= `FRP_SEC_ADDR; // [R5]
          end else if (cfg_valid) begin
            load_q      <= FRP_RUN;
            cfg_rd_q    <= 1'b0;
            load_done_q <= 1'b1;
          end
        end
        FRP_RUN: begin
          cfg_rd_q <= 1'b0;
        end
      endcase
    end
  end

  // program guard: accept only writes that keep or grow protection [R7]
  always_comb begin
    pg_new = pguard_q;
    pg_new[`FRP_PG_SENSE] = wbyte[`FRP_PG_SENSE];
    pg_new[`FRP_PG_HDIS]  = wbyte[`FRP_PG_HDIS];
    pg_new[`FRP_PG_LDIS]  = wbyte[`FRP_PG_LDIS];
    if (pguard_q[`FRP_PG_HDIS]) begin
      pg_new[4:3] = wbyte[4:3]; // [R17]
    end
    if (pguard_q[`FRP_PG_LDIS]) begin
      pg_new[1:0] = wbyte[1:0]; // [R19]
    end
    pg_grow = pg_ok(pguard_q, pg_new);
  end

  // growth check: open-to-protected sense always shrinks, so never;
  // protected-to-open only when no old region meets a new window
  function automatic logic pg_ok(input logic [7:0] o, input logic [7:0] n);
    logic ok;
    ok = 1'b1;
    if (o[`FRP_PG_SENSE] != n[`FRP_PG_SENSE]) begin
      ok = n[`FRP_PG_SENSE] ? 1'b0 : ((o[5] || n[5]) && (o[2] || n[2]));
    end
    if (n[`FRP_PG_SENSE] && o[`FRP_PG_SENSE]) begin
      if (n[5] && !o[5]) ok = 1'b0;
      if (n[2] && !o[2]) ok = 1'b0;
      if (!o[5] && n[4:3] < o[4:3]) ok = 1'b0;
      if (!o[2] && n[1:0] < o[1:0]) ok = 1'b0;
    end else if (!n[`FRP_PG_SENSE] && !o[`FRP_PG_SENSE]) begin
      if (!n[5] && o[5]) ok = 1'b0;
      if (!n[2] && o[2]) ok = 1'b0;
      if (!o[5] && n[4:3] > o[4:3]) ok = 1'b0;
      if (!o[2] && n[1:0] > o[1:0]) ok = 1'b0;
    end
    return ok;
  endfunction : pg_ok

  // program guard register; load at reset sequence, fault fully protects
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pguard_q <= `FRP_PG_FAULT;
    end else if (load_q == FRP_LD_PG && cfg_valid && cfg_rd_q) begin
      pguard_q <= cfg_dbl_fault ? `FRP_PG_FAULT : cfg_data; // [R8] [R9]
    end else if (load_q == FRP_RUN && wr_stb &&
                 wb_adr_i == `FRP_REG_PGUARD && pg_grow) begin
      pguard_q <= pg_new; // [R7]
    end
  end

  // data guard register; writes only grow protection as well
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dguard_q <= `FRP_DG_FAULT;
    end else if (load_q == FRP_LD_DG && cfg_valid) begin
      dguard_q <= cfg_dbl_fault ? `FRP_DG_FAULT : cfg_data; // [R10]
    end else if (load_q == FRP_RUN && wr_stb &&
                 wb_adr_i == `FRP_REG_DGUARD) begin
      if (dguard_q[`FRP_DG_CTRL]) begin
        dguard_q <= {wbyte[7], 3'b000, wbyte[3:0]};
      end else if (!wbyte[7] && wbyte[3:0] >= dguard_q[3:0]) begin
        dguard_q <= {1'b0, 3'b000, wbyte[3:0]};
      end
    end
  end

  // security and option copies loaded with the rest of the field
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sec_q <= 8'hFF;
      opt_q <= 8'hFF;
    end else if (load_q == FRP_LD_REST && cfg_valid &&
                 cfg_addr_q == `FRP_OPT_ADDR) begin
      opt_q <= cfg_data; // [R5]
    end else if (load_q == FRP_LD_REST && cfg_valid) begin
      sec_q <= cfg_data; // [R5]
    end
  end

  // address classification; key bytes decode as array addresses [R2] [R4]
  assign p_hit = (seq_addr >= `FRP_PARR_BASE) && (seq_addr <= `FRP_PARR_TOP);
  assign d_hit = (seq_addr >= `FRP_DARR_BASE) && (seq_addr <= `FRP_DARR_TOP);
  assign blk   = (seq_op == FRP_OP_BLOCK);
  assign d_end = `FRP_DARR_BASE +
                 ({14'h0, dguard_q[3:0]} << `FRP_DSIZE_SHIFT) + 18'h0_00FF;

  frp_pguard_dec u_pdec (
    .guard (pguard_q),
    .addr  (seq_addr),
    .block (blk),
    .prot  (p_prot)
  );

  // data array range protection [R21] [R22] [R14]
  assign d_prot = !dguard_q[`FRP_DG_CTRL] &&
                  (blk || (seq_addr <= d_end));

  // combinational answer; before load completes, everything is protected
  always_comb begin
    if (load_q != FRP_RUN) begin
      seq_prot = 1'b1;
    end else if (seq_data_arr) begin
      seq_prot = d_hit ? d_prot : 1'b1; // [R24] [R13]
    end else begin
      seq_prot = p_hit ? p_prot : 1'b1; // [R24] [R11]
    end
  end

  // violation flag: set by refused launch, cleared by writing 1; set wins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      viol_q <= 1'b0;
    end else if (seq_launch && seq_query && seq_prot) begin
      viol_q <= 1'b1; // [R11] [R13]
    end else if (wr_stb && wb_adr_i == `FRP_REG_STATUS &&
                 wbyte[`FRP_ST_VIOL]) begin
      viol_q <= 1'b0;
    end
  end

  // read mux; unmapped reads zero, unmapped writes ignored [R1]
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (wb_adr_i)
      `FRP_REG_PGUARD: rdata_d[7:0] = pguard_q;
      `FRP_REG_DGUARD: rdata_d[7:0] = dguard_q;
      `FRP_REG_STATUS: rdata_d[`FRP_ST_VIOL] = viol_q;
      `FRP_REG_SEC:    rdata_d[7:0] = sec_q;
      `FRP_REG_OPT:    rdata_d[7:0] = opt_q;
      default:         rdata_d = 32'h0000_0000;
    endcase
  end

  // ack and read data registered; one ack per request
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= rd_stb;
      if (rd_stb) begin
        wb_dat_o <= rdata_d;
      end
    end
  end
endmodule : frp_top
`default_nettype wire

// >>> design/frp_cfg.svh
// frp_cfg.svh: offsets, field positions, reset values and sizes for the
// flash region protection block; included by the package and modules.
// assumes a 40 MHz mclk and a classic wishbone register bus.
// Operation
// [R1] writes to unmapped or reserved locations are ignored; reads there undefined.
// [R2] program array spans global 0x2_0000 to 0x3_FFFF, 128 KB.
// [R3] three regions: lower from 0x3_8000 up, higher from 0x3_FFFF down, rest.
// [R4] eight-byte backdoor key sits at 0x3_FF00 to 0x3_FF07.
// [R5] guard bytes at 0x3_FF0C/0D, option at 0x3_FF0E, security at 0x3_FF0F.
// [R6] software programs 0x3_FF08..0F in one sequence; reserved bytes as 0xFF.
// [R7] program guard writes only take effect when protection grows.
// [R8] program guard loads from byte 0x3_FF0C during reset sequence.
// [R9] double-bit fault on that load: sense clear, all other bits set.
// [R10] data guard fault at load: control clear, size bits all set.
// [R11] program/erase on protected program address refused, violation flag set.
// [R12] program block erase refused if any of its sectors is protected.
// [R13] program/erase on protected data address refused, same flag set.
// [R14] data block erase refused if any data sector is protected.
// [R15] bit 7 sense: clear means regions unprotected, set means protected.
// [R16] bit 5 disables the higher region when 1.
// [R17] higher size bits 4..3 writable only while higher disable set.
// [R18] bit 2 disables the lower region when 1.
// [R19] lower size bits 1..0 writable only while lower disable set.
// [R20] software leaves spare bit 6 erased.
// [R21] data guard bit 7: 0 enables size-field protection, 1 disables all.
// [R22] data range starts 0x0_4400, length (size+1)*256 bytes.
// [R23] higher/lower size encodings held as a configurable lookup.
// [R24] combinational protected answer to the sequencer for any query.
`ifndef FRP_CFG_SVH
`define FRP_CFG_SVH
`define FRP_PARR_BASE     18'h2_0000
`define FRP_PARR_TOP      18'h3_FFFF
`define FRP_LOW_BASE      18'h3_8000
`define FRP_KEY_ADDR      18'h3_FF00
`define FRP_PGUARD_ADDR   18'h3_FF0C
`define FRP_DGUARD_ADDR   18'h3_FF0D
`define FRP_OPT_ADDR      18'h3_FF0E
`define FRP_SEC_ADDR      18'h3_FF0F
`define FRP_DARR_BASE     18'h0_4400
`define FRP_DARR_TOP      18'h0_53FF
`define FRP_DSIZE_SHIFT   8
// register word offsets (byte addresses)
`define FRP_REG_PGUARD    5'h00
`define FRP_REG_DGUARD    5'h04
`define FRP_REG_STATUS    5'h08
`define FRP_REG_SEC       5'h0C
`define FRP_REG_OPT       5'h10
// field positions
`define FRP_PG_SENSE      7
`define FRP_PG_SPARE      6
`define FRP_PG_HDIS       5
`define FRP_PG_LDIS       2
`define FRP_DG_CTRL       7
`define FRP_ST_VIOL       5
// fault load values
`define FRP_PG_FAULT      8'h7F
`define FRP_DG_FAULT      8'h0F
// region sizes in bytes, index = size code (lookup, plain defaults)
`define FRP_HSIZE_0       18'h0_0800
`define FRP_HSIZE_1       18'h0_1000
`define FRP_HSIZE_2       18'h0_2000
`define FRP_HSIZE_3       18'h0_4000
`define FRP_LSIZE_0       18'h0_0400
`define FRP_LSIZE_1       18'h0_0800
`define FRP_LSIZE_2       18'h0_1000
`define FRP_LSIZE_3       18'h0_2000
`endif

// >>> design/frp_pkg.sv
// frp_pkg: types for the flash region protection block.
// assumes frp_cfg.svh is on the include path.
`include "frp_cfg.svh"
package frp_pkg;
  typedef enum logic [3:0] {
    FRP_LD_PG   = 4'b0001,
    FRP_LD_DG   = 4'b0010,
    FRP_LD_REST = 4'b0100,
    FRP_RUN     = 4'b1000
  } frp_load_t;
  typedef enum logic [1:0] {
    FRP_OP_PROG  = 2'b00,
    FRP_OP_SECT  = 2'b01,
    FRP_OP_BLOCK = 2'b10
  } frp_op_t;
endpackage : frp_pkg

// >>> design/frp_pguard_dec.sv
// frp_pguard_dec: program array protection decode for one address.
// assumes a global 18-bit address; purely combinational.
`timescale 1ns/10ps
`default_nettype none
`include "frp_cfg.svh"
module frp_pguard_dec
  import frp_pkg::*;
(
  input  wire logic [7:0]  guard,
  input  wire logic [17:0] addr,
  input  wire logic        block,
  output logic             prot
);
  logic [17:0] hsize;
  logic [17:0] lsize;
  logic        in_h;
  logic        in_l;
  logic        any_h;
  logic        any_l;
  logic        any_rest;
  // size lookup for both regions [R23]
  always_comb begin
    unique case (guard[4:3])
      2'd0: hsize = `FRP_HSIZE_0;
      2'd1: hsize = `FRP_HSIZE_1;
      2'd2: hsize = `FRP_HSIZE_2;
      2'd3: hsize = `FRP_HSIZE_3;
    endcase
    unique case (guard[1:0])
      2'd0: lsize = `FRP_LSIZE_0;
      2'd1: lsize = `FRP_LSIZE_1;
      2'd2: lsize = `FRP_LSIZE_2;
      2'd3: lsize = `FRP_LSIZE_3;
    endcase
  end
  // region membership; higher down from top, lower up from base [R3] [R16] [R18]
  assign in_h = !guard[`FRP_PG_HDIS] &&
                (addr > (`FRP_PARR_TOP - hsize));
  assign in_l = !guard[`FRP_PG_LDIS] && (addr >= `FRP_LOW_BASE) &&
                (addr < (`FRP_LOW_BASE + lsize));
  assign any_h = !guard[`FRP_PG_HDIS];
  assign any_l = !guard[`FRP_PG_LDIS];
  // rest of array holds at least one address outside both regions
  assign any_rest = 1'b1;
  // sense bit picks whether regions are the protected set [R15]
  always_comb begin
    if (guard[`FRP_PG_SENSE]) begin
      prot = block ? (any_h || any_l) : (in_h || in_l); // [R12]
    end else begin
      prot = block ? any_rest : !(in_h || in_l); // [R12]
    end
  end
endmodule : frp_pguard_dec
`default_nettype wire

// >>> dv/frp_asserts.sv
// frp_asserts: port-level checks bound to frp_top.
// assumes the single mclk domain and active-low reset_n.
`timescale 1ns/10ps
`default_nettype none
module frp_asserts (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        cfg_rd_q,
  input wire logic [17:0] cfg_addr_q,
  input wire logic        cfg_valid,
  input wire logic        seq_query,
  input wire logic        seq_data_arr,
  input wire logic [17:0] seq_addr,
  input wire logic        seq_prot,
  input wire logic        load_done_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // bus answer timing
  a_ack_next:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  // reset-time loading order
  a_cfg_legal:
    assert property (cfg_rd_q |-> cfg_addr_q inside
      {18'h3_FF0C, 18'h3_FF0D, 18'h3_FF0E, 18'h3_FF0F})
    else $error("config read off the guard bytes");
  a_cfg_hold:
    assert property (cfg_rd_q && !cfg_valid |=> $stable(cfg_addr_q))
    else $error("config address moved before valid");
  a_pg_then_dg:
    assert property (cfg_valid && cfg_rd_q && cfg_addr_q == 18'h3_FF0C
      |=> cfg_addr_q == 18'h3_FF0D)
    else $error("data guard byte not read next");
  a_dg_then_opt:
    assert property (cfg_valid && cfg_rd_q && cfg_addr_q == 18'h3_FF0D
      |=> cfg_addr_q == 18'h3_FF0E)
    else $error("option byte not read next");
  a_opt_then_sec:
    assert property (cfg_valid && cfg_rd_q && cfg_addr_q == 18'h3_FF0E
      |=> cfg_addr_q == 18'h3_FF0F)
    else $error("security byte not read next");
  a_done_quiet:
    assert property (load_done_q |=> load_done_q && !cfg_rd_q)
    else $error("loading resumed after done");
  // queries outside the program array
  a_outside_prot:
    assert property (seq_query && !seq_data_arr && seq_addr < 18'h2_0000
      |-> seq_prot)
    else $error("address below program array open");
endmodule : frp_asserts
bind frp_top frp_asserts u_asserts (.mclk, .reset_n, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .cfg_rd_q, .cfg_addr_q, .cfg_valid, .seq_query, .seq_data_arr,
  .seq_addr, .seq_prot, .load_done_q);
`default_nettype wire

// >>> dv/frp_cfg_model.sv
// frp_cfg_model: configuration field answering reset-time byte reads.
// assumes each read is held on cfg_rd_q until cfg_valid.
`timescale 1ns/10ps
`default_nettype none
module frp_cfg_model (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        cfg_rd_q,
  input  wire logic [17:0] cfg_addr_q,
  input  wire logic        fault,
  input  wire logic [1:0]  slow,
  output logic             cfg_valid,
  output logic [7:0]       cfg_data,
  output logic             cfg_dbl_fault
);
  logic [1:0] wait_q;
  // answer after slow idle cycles; data inverted outside valid
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_valid     <= 1'b0;
      cfg_data      <= 8'h00;
      cfg_dbl_fault <= 1'b0;
      wait_q        <= 2'h0;
    end else if (cfg_valid) begin
      cfg_valid     <= 1'b0;
      cfg_data      <= ~cfg_data;
      cfg_dbl_fault <= 1'b0;
      wait_q        <= 2'h0;
    end else if (cfg_rd_q && wait_q == slow) begin
      cfg_valid     <= 1'b1;
      cfg_dbl_fault <= fault;
      // phrase bytes answer as one programmed set
      case (cfg_addr_q)
        18'h3_FF0C: cfg_data <= 8'hFF;
        18'h3_FF0D: cfg_data <= 8'h80;
        18'h3_FF0E: cfg_data <= 8'h5A;
        18'h3_FF0F: cfg_data <= 8'hA5;
        default:    cfg_data <= ~cfg_data;
      endcase
    end else if (cfg_rd_q) begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule : frp_cfg_model
`default_nettype wire

// >>> dv/tb_flash_region_protection.sv
// tb_flash_region_protection: directed scenarios for frp_top.
// assumes frp_cfg_model stands in for the configuration field.
`timescale 1ns/10ps
`default_nettype none
module tb_flash_region_protection;
  import frp_pkg::*;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic        cfg_rd;
  logic [17:0] cfg_addr;
  logic        cfg_valid;
  logic [7:0]  cfg_data;
  logic        cfg_flt;
  logic        query = 1'b0;
  logic        darr = 1'b0;
  logic [1:0]  op = 2'h0;
  logic [17:0] saddr = 18'h0_0000;
  logic        prot;
  logic        launch = 1'b0;
  logic        done;
  logic        fault = 1'b0;
  logic [1:0]  slow = 2'h0;
  int          miscompares = 0;
  int          tests_run = 0;
  int          cycles = 0;
  // block under test and its configuration field
  frp_top u_dut (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cfg_rd_q(cfg_rd),
    .cfg_addr_q(cfg_addr), .cfg_valid(cfg_valid), .cfg_data(cfg_data),
    .cfg_dbl_fault(cfg_flt), .seq_query(query), .seq_data_arr(darr),
    .seq_op(op), .seq_addr(saddr), .seq_prot(prot), .seq_launch(launch),
    .load_done_q(done));
  frp_cfg_model u_cfg (.mclk(mclk), .reset_n(reset_n), .cfg_rd_q(cfg_rd),
    .cfg_addr_q(cfg_addr), .fault(fault), .slow(slow),
    .cfg_valid(cfg_valid), .cfg_data(cfg_data), .cfg_dbl_fault(cfg_flt));
  // 40 MHz clock and run limit
  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  task end_sim;
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk
  // one classic wishbone cycle, held until ack
  task bus(input logic w, input logic [4:0] a, input logic [7:0] d,
           output logic [7:0] q);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask : bus
  task wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task rd(input logic [4:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, e, q);
  endtask : rd
  task stat(input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, 5'h08, 8'h00, q);
    chk("violation", e, q & 8'h20);
  endtask : stat
  task qry(input logic d, input logic [1:0] o, input logic [17:0] a,
           input logic e);
    @(posedge mclk);
    darr <= d;
    op <= o;
    saddr <= a;
    query <= 1'b1;
    #1 chk("seq_prot", {7'h00, e}, {7'h00, prot});
  endtask : qry
  task hit;
    @(posedge mclk);
    launch <= 1'b1;
    @(posedge mclk);
    launch <= 1'b0;
  endtask : hit
  task rst(input logic f);
    int n;
    @(posedge mclk);
    reset_n <= 1'b0;
    fault <= f;
    slow <= {f, f};
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    for (n = 0; n < 200 && done !== 1'b1; n++) @(posedge mclk);
    chk("load_done", 8'h01, {7'h00, done});
  endtask : rst
  // scenarios
  task t_load;
    rd(5'h00, 8'hFF, "pguard");
    rd(5'h04, 8'h80, "dguard");
    rd(5'h0C, 8'hA5, "security");
    rd(5'h10, 8'h5A, "option");
    qry(1'b0, FRP_OP_PROG, 18'h3_0000, 1'b0);
    qry(1'b0, FRP_OP_PROG, 18'h1_0000, 1'b1);
    qry(1'b1, FRP_OP_BLOCK, 18'h0_4400, 1'b0);
  endtask : t_load
  task t_pguard;
    wr(5'h00, 8'hFE);
    rd(5'h00, 8'hFE, "low size");
    wr(5'h00, 8'hFA);
    rd(5'h00, 8'hFA, "low on");
    qry(1'b0, FRP_OP_PROG, 18'h3_8FFF, 1'b1);
    qry(1'b0, FRP_OP_SECT, 18'h3_9000, 1'b0);
    wr(5'h00, 8'hF9);
    wr(5'h00, 8'hFE);
    wr(5'h00, 8'h7A);
    rd(5'h00, 8'hFA, "no shrink");
    wr(5'h00, 8'hDA);
    wr(5'h00, 8'hCA);
    rd(5'h00, 8'hDA, "high on");
    qry(1'b0, FRP_OP_PROG, 18'h3_BFFF, 1'b0);
    qry(1'b0, FRP_OP_PROG, 18'h3_C000, 1'b1);
    qry(1'b0, FRP_OP_BLOCK, 18'h3_0000, 1'b1);
  endtask : t_pguard
  task t_viol;
    qry(1'b0, FRP_OP_PROG, 18'h3_0000, 1'b0);
    hit();
    stat(8'h00);
    qry(1'b0, FRP_OP_PROG, 18'h3_FFFF, 1'b1);
    hit();
    stat(8'h20);
    wr(5'h08, 8'h20);
    stat(8'h00);
  endtask : t_viol
  task t_data;
    wr(5'h04, 8'h03);
    rd(5'h04, 8'h03, "dguard on");
    qry(1'b1, FRP_OP_PROG, 18'h0_47FF, 1'b1);
    qry(1'b1, FRP_OP_SECT, 18'h0_4800, 1'b0);
    qry(1'b1, FRP_OP_BLOCK, 18'h0_4800, 1'b1);
    qry(1'b1, FRP_OP_PROG, 18'h0_4400, 1'b1);
    hit();
    stat(8'h20);
    wr(5'h04, 8'h02);
    wr(5'h04, 8'h83);
    wr(5'h14, 8'h00);
    rd(5'h04, 8'h03, "dguard kept");
  endtask : t_data
  task t_fault;
    rst(1'b1);
    rd(5'h00, 8'h7F, "pguard fault");
    rd(5'h04, 8'h0F, "dguard fault");
    wr(5'h00, 8'hFF);
    rd(5'h00, 8'h7F, "pguard locked");
    qry(1'b0, FRP_OP_PROG, 18'h2_0000, 1'b1);
    qry(1'b1, FRP_OP_PROG, 18'h0_53FF, 1'b1);
  endtask : t_fault
  // main sequence
  initial begin
    rst(1'b0);
    t_load();
    t_pguard();
    t_viol();
    t_data();
    t_fault();
    end_sim();
  end
endmodule : tb_flash_region_protection
`default_nettype wire
